// ### rtl/osd_polarity_color_window_regs.sv
/*
 * osd_polarity_color_window_regs: AHB-Lite register block that sets sync
 * input sense, video output polarity, raster/extra/border colours,
 * the display interrupt source, and a vertical window counted in lines.
 * Assumes hsync/vsync arrive asynchronously on pins and that the display
 * engine supplies pixel classes and block-end pulses on hclk.
 */
// Chosen here: the AHB-Lite register port.
module osd_polarity_color_window_regs
   import osd_pkg::*;
#(
   parameter int unsigned ADDR_W = 12
) (
   input  wire logic              hclk,
   input  wire logic              hresetn,
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   input  wire logic              hsync_in,
   input  wire logic              vsync_in,
   input  wire osd_px_t           px,
   input  wire logic              osd_block_end,
   input  wire logic              caption_block_end,
   output osd_vid_t               vid_out,
   output logic                   display_irq,
   output logic                   window_active,
   output logic                   dot_line_odd
);

   ////////////////////////////////////////////////////////////////////////////
   // all state of the block

   typedef struct packed {
      logic [7:0]            pol;
      logic [7:0]            raster;
      logic [7:0]            extra;
      logic [7:0]            border;
      logic [7:0]            win1_lo;
      logic [7:0]            win2_lo;
      logic [1:0]            win1_hi;
      logic [1:0]            win2_hi;
      logic                  hs_s1;
      logic                  hs_s2;
      logic                  vs_s1;
      logic                  vs_s2;
      logic                  hs_prev;
      logic                  vs_prev;
      logic [LINE_W-1:0]     line_cnt;
      logic [LINE_CLK_W-1:0] clk_cnt;
      logic [LINE_CLK_W-1:0] half_len;
      logic                  dph_wr;
      logic [ADDR_W-1:0]     dph_addr;
      logic [31:0]           rdata;
      osd_vid_t              vid;
      logic                  irq;
      logic                  win_act;
      logic                  dot_odd;
   } osd_state_t;

   osd_state_t st_r;
   osd_state_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // combinational next state

   logic                  aphase;
   logic                  hs_lvl;
   logic                  vs_lvl;
   logic                  hs_edge;
   logic                  vs_edge;
   logic [LINE_W-1:0]     bound_top;
   logic [LINE_W-1:0]     bound_bot;
   logic [2:0]            rgb_sel;
   logic [1:0]            aux_sel;
   logic [7:0]            rd_byte;

   always_comb begin
      st_nxt = st_r;

      // bus: address phase only when the previous transfer has finished
      aphase = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == 2'b11);

      // data-phase write; masks keep reserved and read-only bits intact
      if (st_r.dph_wr) begin
         unique case (st_r.dph_addr[11:0])
            ADDR_POL: begin
               st_nxt.pol = (st_r.pol & ~POL_WMASK)
                          | (hwdata[7:0] & POL_WMASK);
            end
            ADDR_RASTER: begin
               st_nxt.raster = hwdata[7:0] & RASTER_WMASK;
            end
            ADDR_EXTRA: begin
               st_nxt.extra = hwdata[7:0] & COLOR_WMASK;
            end
            ADDR_BORDER: begin
               st_nxt.border = hwdata[7:0] & COLOR_WMASK;
            end
            ADDR_WIN1_LO: begin
               st_nxt.win1_lo = hwdata[7:0];
            end
            ADDR_WIN2_LO: begin
               st_nxt.win2_lo = hwdata[7:0];
            end
            ADDR_WIN1_HI: begin
               st_nxt.win1_hi = hwdata[1:0];
            end
            ADDR_WIN2_HI: begin
               st_nxt.win2_hi = hwdata[1:0];
            end
            default: begin
               st_nxt.win2_hi = st_r.win2_hi;
            end
         endcase
      end

      // sync pins: two flops before any logic looks at them
      st_nxt.hs_s1 = hsync_in;
      st_nxt.hs_s2 = st_r.hs_s1;
      st_nxt.vs_s1 = vsync_in;
      st_nxt.vs_s2 = st_r.vs_s1;

      // sense select turns each pin into an active-high level
      hs_lvl = st_r.hs_s2 ^ st_r.pol[POL_HSYNC];
      vs_lvl = st_r.vs_s2 ^ st_r.pol[POL_VSYNC];
      hs_edge = hs_lvl & ~st_r.hs_prev;
      vs_edge = vs_lvl & ~st_r.vs_prev;
      st_nxt.hs_prev = hs_lvl;
      st_nxt.vs_prev = vs_lvl;

      // line timing: clocks per line, lines since vsync
      if (hs_edge) begin
         st_nxt.clk_cnt  = '0;
         st_nxt.half_len = {1'b0, st_r.clk_cnt[LINE_CLK_W-1:1]};
         if (st_r.line_cnt != {LINE_W{1'b1}}) begin
            st_nxt.line_cnt = st_r.line_cnt + 1'b1;
         end
      end else if (st_r.clk_cnt != {LINE_CLK_W{1'b1}}) begin
         st_nxt.clk_cnt = st_r.clk_cnt + 1'b1;
      end

      // vsync in the first half of a line marks an odd field
      if (vs_edge) begin
         st_nxt.line_cnt = '0;
         st_nxt.pol[POL_FIELD] = (st_r.clk_cnt < st_r.half_len);
      end

      // window: first boundary inclusive, second exclusive
      bound_top = {st_r.win1_hi, st_r.win1_lo};
      bound_bot = {st_r.win2_hi, st_r.win2_lo};
      st_nxt.win_act = (st_r.line_cnt >= bound_top)
                     & (st_r.line_cnt < bound_bot);

      // which dot line is shown flips with the field and the select bit
      st_nxt.dot_odd = st_r.pol[POL_FIELD] ^ st_r.pol[POL_DOTSEL];

      // colour priority: font, border, extra font, raster
      rgb_sel = 3'h0;
      aux_sel = 2'h0;
      if (px.font_on) begin
         rgb_sel = px.font_rgb;
         aux_sel = px.font_aux;
      end else if (px.border_on) begin
         rgb_sel = st_r.border[2:0];
      end else if (px.extra_on) begin
         rgb_sel = st_r.extra[2:0];
      end else if (px.raster_on) begin
         rgb_sel = st_r.raster[2:0];
         aux_sel = {st_r.raster[RAS_AUX_B], st_r.raster[RAS_AUX_A]};
      end

      // inversion after selection so blanking also flips level
      st_nxt.vid.rgb = rgb_sel ^ {3{st_r.pol[POL_RGB]}};
      st_nxt.vid.aux = aux_sel
                     ^ {st_r.pol[POL_AUX_B], st_r.pol[POL_AUX_A]};

      // display interrupt follows one of the two block-end pulses
      st_nxt.irq = st_r.raster[RAS_IRQSEL] ? caption_block_end
                                            : osd_block_end;

      // read data sampled from next state so a write just before is seen
      rd_byte = 8'h00;
      unique case (haddr[11:0])
         ADDR_POL:     rd_byte = st_nxt.pol & (POL_WMASK | POL_RESET);
         ADDR_RASTER:  rd_byte = st_nxt.raster;
         ADDR_EXTRA:   rd_byte = st_nxt.extra;
         ADDR_BORDER:  rd_byte = st_nxt.border;
         ADDR_WIN1_LO: rd_byte = st_nxt.win1_lo;
         ADDR_WIN2_LO: rd_byte = st_nxt.win2_lo;
         ADDR_WIN1_HI: rd_byte = {6'h00, st_nxt.win1_hi};
         ADDR_WIN2_HI: rd_byte = {6'h00, st_nxt.win2_hi};
         default:      rd_byte = 8'h00;
      endcase

      st_nxt.dph_wr = 1'b0;
      if (aphase) begin
         st_nxt.dph_wr   = hwrite;
         st_nxt.dph_addr = haddr;
         st_nxt.rdata    = hwrite ? st_r.rdata : {24'h000000, rd_byte};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r          <= '0;
         st_r.pol      <= POL_RESET;
         st_r.raster   <= REG_RESET;
         st_r.extra    <= REG_RESET;
         st_r.border   <= REG_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   // zero wait states; every access answers OKAY
   assign hreadyout     = 1'b1;
   assign hresp         = 1'b0;
   assign hrdata        = st_r.rdata;
   assign vid_out       = st_r.vid;
   assign display_irq   = st_r.irq;
   assign window_active = st_r.win_act;
   assign dot_line_odd  = st_r.dot_odd;

endmodule

// ### rtl/osd_pkg.sv
/*
 * osd_pkg: register map, field layout, reset values and carrier types
 * for the on-screen display polarity, colour and window register block.
 * Assumes a 32-bit AHB-Lite slave port with one register per word.
 */
package osd_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register indices as printed; byte address is four times the index
   localparam logic [11:0] IDX_POL     = 12'h217;
   localparam logic [11:0] IDX_RASTER  = 12'h218;
   localparam logic [11:0] IDX_EXTRA   = 12'h219;
   localparam logic [11:0] IDX_BORDER  = 12'h21b;
   localparam logic [11:0] IDX_WIN1_LO = 12'h21c;
   localparam logic [11:0] IDX_WIN2_LO = 12'h21d;
   localparam logic [11:0] IDX_WIN1_HI = 12'h21e;
   localparam logic [11:0] IDX_WIN2_HI = 12'h21f;

   localparam logic [11:0] ADDR_POL     = {IDX_POL[9:0], 2'b00};
   localparam logic [11:0] ADDR_RASTER  = {IDX_RASTER[9:0], 2'b00};
   localparam logic [11:0] ADDR_EXTRA   = {IDX_EXTRA[9:0], 2'b00};
   localparam logic [11:0] ADDR_BORDER  = {IDX_BORDER[9:0], 2'b00};
   localparam logic [11:0] ADDR_WIN1_LO = {IDX_WIN1_LO[9:0], 2'b00};
   localparam logic [11:0] ADDR_WIN2_LO = {IDX_WIN2_LO[9:0], 2'b00};
   localparam logic [11:0] ADDR_WIN1_HI = {IDX_WIN1_HI[9:0], 2'b00};
   localparam logic [11:0] ADDR_WIN2_HI = {IDX_WIN2_HI[9:0], 2'b00};

   ////////////////////////////////////////////////////////////////////////////
   // polarity control fields
   localparam int unsigned POL_HSYNC  = 0;
   localparam int unsigned POL_VSYNC  = 1;
   localparam int unsigned POL_RGB    = 2;
   localparam int unsigned POL_AUX_A  = 4;
   localparam int unsigned POL_AUX_B  = 5;
   localparam int unsigned POL_DOTSEL = 6;
   localparam int unsigned POL_FIELD  = 7;
   // raster colour fields
   localparam int unsigned RAS_AUX_A  = 5;
   localparam int unsigned RAS_AUX_B  = 6;
   localparam int unsigned RAS_IRQSEL = 7;

   // writable bit masks
   localparam logic [7:0] POL_WMASK    = 8'h77;
   localparam logic [7:0] RASTER_WMASK = 8'he7;
   localparam logic [7:0] COLOR_WMASK  = 8'h1f;
   localparam logic [7:0] HI_WMASK     = 8'h03;

   localparam logic [7:0] POL_RESET   = 8'h80;
   localparam logic [7:0] REG_RESET   = 8'h00;

   localparam int unsigned LINE_W     = 10;
   localparam int unsigned LINE_CLK_W = 16;

   localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

   ////////////////////////////////////////////////////////////////////////////
   // pixel classes from the display engine, one dot at a time
   typedef struct packed {
      logic       font_on;
      logic [2:0] font_rgb;
      logic [1:0] font_aux;
      logic       extra_on;
      logic       border_on;
      logic       raster_on;
   } osd_px_t;

   // video towards the display: r,g,b then aux a,b
   typedef struct packed {
      logic [2:0] rgb;
      logic [1:0] aux;
   } osd_vid_t;

endpackage

// ### tb/osd_assertions.sv
/*
 * osd_assertions: port checks for the polarity, colour and window block.
 * Assumes one hclk domain and hready tied to hreadyout.
 */
module osd_assertions
   import osd_pkg::*;
#(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic              hclk,
   input wire logic              hresetn,
   input wire logic              hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire osd_px_t           px,
   input wire logic              osd_block_end,
   input wire logic              caption_block_end,
   input wire osd_vid_t          vid_out,
   input wire logic              display_irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic              wp_r;
   logic [ADDR_W-1:0] wa_r;
   logic [7:0]        pol_r, ras_r, ext_r, bor_r;
   logic [4:0]        inv_v, ras_v, ext_v, bor_v;
   // shadow of written bytes, since the register state is not on the ports
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wp_r <= 1'b0;
         wa_r <= '0;
         pol_r <= 8'h00;
         ras_r <= 8'h00;
         ext_r <= 8'h00;
         bor_r <= 8'h00;
      end else begin
         wp_r <= hsel && hready && htrans[1] && hwrite;
         wa_r <= haddr;
         if (wp_r && wa_r == ADDR_POL) pol_r <= hwdata[7:0];
         if (wp_r && wa_r == ADDR_RASTER) ras_r <= hwdata[7:0];
         if (wp_r && wa_r == ADDR_EXTRA) ext_r <= hwdata[7:0];
         if (wp_r && wa_r == ADDR_BORDER) bor_r <= hwdata[7:0];
      end
   end
   // video word is {blue,green,red,aux b,aux a}, red in the lowest rgb bit
   assign inv_v = {{3{pol_r[2]}}, pol_r[5], pol_r[4]};
   assign ras_v = {ras_r[2:0], ras_r[6], ras_r[5]};
   assign ext_v = {ext_r[2:0], 2'b00};
   assign bor_v = {bor_r[2:0], 2'b00};
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd(logic [ADDR_W-1:0] a);
      hsel && hready && htrans[1] && !hwrite && haddr == a;
   endsequence
   a_raster_path: assert property (
      px == 9'h001 |=> vid_out == $past(ras_v ^ inv_v)) else $error("raster colour wrong");
   a_border_path: assert property (
      px == 9'h002 |=> vid_out == $past(bor_v ^ inv_v)) else $error("border colour wrong");
   a_extra_path: assert property (
      px == 9'h004 |=> vid_out == $past(ext_v ^ inv_v)) else $error("extra colour wrong");
   a_font_sense: assert property (
      px.font_on |=> vid_out == $past({px.font_rgb, px.font_aux} ^ inv_v))
      else $error("font output sense wrong");
   a_blank_sense: assert property (
      px == 9'h000 |=> vid_out == $past(inv_v)) else $error("blank output sense wrong");
   a_irq_source: assert property (
      1'b1 |=> display_irq == $past(ras_r[7] ? caption_block_end : osd_block_end))
      else $error("display interrupt source wrong");
   a_pol_read: assert property (
      s_rd(ADDR_POL) |=> hrdata[6:0] == (pol_r[6:0] & 7'h77) && hrdata[31:8] == 24'h0)
      else $error("polarity readback wrong");
   a_raster_read: assert property (
      s_rd(ADDR_RASTER) |=> hrdata == {24'h0, ras_r & RASTER_WMASK})
      else $error("raster readback wrong");
   a_extra_read: assert property (
      s_rd(ADDR_EXTRA) |=> hrdata == {24'h0, ext_r & COLOR_WMASK})
      else $error("extra readback wrong");
   a_border_read: assert property (
      s_rd(ADDR_BORDER) |=> hrdata == {24'h0, bor_r & COLOR_WMASK})
      else $error("border readback wrong");
endmodule
bind osd_polarity_color_window_regs osd_assertions #(.ADDR_W(ADDR_W)) osd_assertions_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .px(px),
   .osd_block_end(osd_block_end), .caption_block_end(caption_block_end),
   .vid_out(vid_out), .display_irq(display_irq));

// ### tb/osd_video_partner.sv
/*
 * osd_video_partner: video source making hsync and vsync lines.
 * Assumes the bench sets the pin sense to match the polarity register.
 */
module osd_video_partner (
   input  wire logic hclk,
   input  wire logic hsync_neg,
   input  wire logic vsync_neg,
   output logic      hsync_in,
   output logic      vsync_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic hs = 1'b0;
   logic vs = 1'b0;
   // idle pins sit at the inactive level of the chosen sense
   assign hsync_in = hs ^ hsync_neg;
   assign vsync_in = vs ^ vsync_neg;
   // one line of len cycles; vsync pulse at cycle vat, none if negative
   task automatic line(input int len, input int vat);
      for (int i = 0; i < len; i++) begin
         @(posedge hclk);
         hs <= (i < 4);
         vs <= (vat >= 0 && i >= vat && i < vat + 4);
      end
   endtask
endmodule

// ### tb/test_osd_polarity_color_window_regs.sv
/*
 * test_osd_polarity_color_window_regs: self-checking bench, AHB-Lite master.
 * Assumes zero-wait slave with hready looped back from hreadyout.
 */
module test_osd_polarity_color_window_regs
   import osd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hneg = 0, vneg = 0;
   logic osd_block_end = 0, caption_block_end = 0;
   logic [11:0] haddr = '0;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = '0, hrdata, d;
   logic        hreadyout, hresp, hsync_in, vsync_in, display_irq, window_active, dot_line_odd;
   osd_px_t     px = '0;
   osd_vid_t    vid_out;
   int          n_mismatch = 0, cmp_count = 0;
   localparam logic [11:0] RA [9] = '{ADDR_POL, ADDR_RASTER, ADDR_EXTRA, ADDR_BORDER,
      ADDR_WIN1_LO, ADDR_WIN2_LO, ADDR_WIN1_HI, ADDR_WIN2_HI, 12'h800};
   localparam logic [7:0] WV [9] = '{8'h7f, 8'hff, 8'he7, 8'he7, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
   localparam logic [7:0] EV [9] = '{8'h77, 8'he7, 8'h07, 8'h07, 8'hff, 8'hff, 8'h03, 8'h03, 0};
   localparam logic [8:0] PV [5] = '{9'h001, 9'h002, 9'h004, 9'h000, 9'h18f};
   localparam logic [4:0] VE [5] = '{5'h0a, 5'h0d, 5'h15, 5'h1d, 5'h0c};
   always #50 hclk = ~hclk;
   osd_polarity_color_window_regs osd_polarity_color_window_regs_inst (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .hsync_in(hsync_in),
      .vsync_in(vsync_in), .px(px), .osd_block_end(osd_block_end),
      .caption_block_end(caption_block_end), .vid_out(vid_out), .display_irq(display_irq),
      .window_active(window_active), .dot_line_odd(dot_line_odd));
   osd_video_partner osd_video_partner_inst (.hclk(hclk), .hsync_neg(hneg),
      .vsync_neg(vneg), .hsync_in(hsync_in), .vsync_in(vsync_in));
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         $display("[FAIL] %0t exp %h got %h", $time, e, g);
         n_mismatch++;
      end
   endtask
   task automatic wait_rdy();
      int i;
      i = 0;
      do begin
         @(posedge hclk);
         i++;
      end while (hreadyout !== 1'b1 && i < 20);
      if (hreadyout !== 1'b1) begin
         n_mismatch++;
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      hsel <= 1; haddr <= a; hwrite <= 1; htrans <= HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'b00; hwdata <= {24'h0, v};
      wait_rdy();
   endtask
   task automatic rd(input logic [11:0] a);
      hsel <= 1; haddr <= a; hwrite <= 0; htrans <= HTRANS_NONSEQ;
      wait_rdy();
      htrans <= 2'b00;
      wait_rdy();
      d = hrdata;
      chk(32'h0, {31'h0, hresp});
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // reset values, writable masks, unmapped place; write then read, an idle cycle between
   task automatic t_regs();
      for (int i = 0; i < 9; i++) begin
         rd(RA[i]);
         chk({24'h0, i == 0 ? POL_RESET : REG_RESET}, d);
         wr(RA[i], WV[i]);
         rd(RA[i]);
         chk(EV[i], d & (i == 0 ? 32'hffffff7f : '1));
         wr(RA[i], 8'h00);
      end
   endtask
   task automatic t_video();
      wr(ADDR_RASTER, 8'h65);
      wr(ADDR_EXTRA, 8'h02);
      wr(ADDR_BORDER, 8'h04);
      wr(ADDR_POL, 8'h14);
      for (int i = 0; i < 5; i++) begin
         px <= PV[i];
         @(posedge hclk);
         #1 chk(VE[i], vid_out);
         @(posedge hclk);
      end
      px <= '0;
   endtask
   task automatic pulse(input logic o, input logic c, input logic e);
      osd_block_end <= o; caption_block_end <= c;
      @(posedge hclk);
      osd_block_end <= 0; caption_block_end <= 0;
      #1 chk(e, display_irq);
      @(posedge hclk);
   endtask
   task automatic t_irq();
      for (int s = 0; s < 2; s++) begin
         wr(ADDR_RASTER, {s[0], 7'h0});
         pulse(1, 0, !s[0]);
         pulse(0, 1, s[0]);
      end
   endtask
   // top 2 inclusive, bottom 4 exclusive, counted in whole lines
   task automatic t_window(input logic n);
      wr(ADDR_POL, {6'h0, n, n});
      hneg <= n; vneg <= n;
      wr(ADDR_WIN1_LO, 8'h02);
      wr(ADDR_WIN2_LO, 8'h04);
      osd_video_partner_inst.line(20, -1);
      osd_video_partner_inst.line(20, 10);
      for (int k = 1; k < 6; k++) begin
         osd_video_partner_inst.line(20, -1);
         chk(k >= 2 && k < 4, window_active);
      end
   endtask
   task automatic t_field();
      wr(ADDR_POL, 8'h00);
      hneg <= 0; vneg <= 0;
      osd_video_partner_inst.line(20, -1);
      osd_video_partner_inst.line(20, 5);
      rd(ADDR_POL);
      chk(1, d[7]);
      chk(1, dot_line_odd);
      wr(ADDR_POL, 8'h40);
      rd(ADDR_POL);
      chk(0, dot_line_odd);
      osd_video_partner_inst.line(20, -1);
      osd_video_partner_inst.line(20, 15);
      rd(ADDR_POL);
      chk(32'h40, d);
      chk(1, dot_line_odd);
   endtask
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      t_regs();
      t_video();
      t_irq();
      t_window(0);
      t_window(1);
      t_field();
      hresetn <= 0;
      @(posedge hclk);
      hresetn <= 1;
      @(posedge hclk);
      rd(ADDR_POL);
      chk({24'h0, POL_RESET}, d);
      report_and_stop();
   end
endmodule
